// ---- hdl/acc_pkg.sv ----
/*
 * Package for the analog comparator control block: register map, field
 * positions, reset values and the packed state record of the block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package acc_pkg;
    // Register byte offsets
    localparam int ACC_ADDR_W = 8;
    localparam logic [7:0] ACC_OFS_CTRL_STATUS = 8'h30;
    localparam logic [7:0] ACC_OFS_CONV_B = 8'h34;
    localparam logic [7:0] ACC_OFS_DIGIN_DIS = 8'h38;
    localparam logic [7:0] ACC_OFS_MISC = 8'h3C;
    localparam logic [7:0] ACC_OFS_IRQ_STATUS = 8'h40;
    localparam logic [7:0] ACC_OFS_IRQ_MASK = 8'h44;
    // Comparator control and status fields
    localparam int ACC_B_DISABLE = 7;
    localparam int ACC_B_BANDGAP = 6;
    localparam int ACC_B_OUT = 5;
    localparam int ACC_B_FLAG = 4;
    localparam int ACC_B_IRQ_EN = 3;
    localparam int ACC_B_CAPTURE = 2;
    localparam int ACC_B_MODE = 0;
    // Other fields
    localparam int ACC_B_NEG_MUX = 6;
    localparam int ACC_B_NEG_DIGIN = 1;
    localparam int ACC_B_POS_DIGIN = 0;
    localparam int ACC_B_CONV_EN = 0;
    localparam int ACC_B_CHAN = 1;
    localparam int ACC_B_GIE = 4;
    localparam int ACC_B_EVT = 0;
    // Interrupt modes
    localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
    localparam logic [1:0] ACC_MODE_RSVD = 2'h1;
    localparam logic [1:0] ACC_MODE_FALL = 2'h2;
    localparam logic [1:0] ACC_MODE_RISE = 2'h3;
    // Bus responses
    localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cmp_disable;
        logic bandgap_select;
        logic cmp_irq_flag;
        logic cmp_irq_enable;
        logic capture_route_enable;
        logic [1:0] irq_mode;
        logic neg_mux_enable;
        logic neg_pin_digin_disable;
        logic pos_pin_digin_disable;
        logic converter_enable;
        logic [2:0] channel_select;
        logic global_irq_enable;
        logic irq_mask;
        logic cmp_raw;
        logic sync1;
        logic cmp_output_status;
        logic out_prev;
        logic irq;
        logic capture_trigger;
        logic pos_port_bit;
        logic neg_port_bit;
    } acc_state_t;

    localparam acc_state_t ACC_RESET_STATE = '0;
endpackage

// ---- hdl/acc_top.sv ----
/*
 * Analog comparator control: input selection, result synchronisation,
 * edge events, interrupt flag and capture routing, AXI4-Lite registers.
 * Assumes analog voltages arrive as unsigned codes synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - The raw result is high while the positive input exceeds the negative.
// - Mux enable with converter off picks channel 0-7 as negative, else pin.
// - Bandgap select feeds the reference to the positive input, else the pin.
// - The disable bit powers the comparator off and may be written any time.
// - The result is synchronised to the clock before it shows as status.
// - An output event matching the interrupt mode sets the interrupt flag.
// - The flag clears when its vector runs or software writes a one to it.
// - Interrupt is requested only with flag, enable, global enable and mask set.
// - Mode 00 is toggle, 01 reserved, 10 falling and 11 rising edge.
// - Capture routing feeds the output to the timer capture logic.
// - Digital input disable turns a pin buffer off and reads its port bit 0.
module acc_top
    import acc_pkg::*;
#(
    parameter int LEVEL_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [LEVEL_W-1:0] cmp_pos_pin,
    input wire logic [LEVEL_W-1:0] cmp_neg_pin,
    input wire logic [LEVEL_W-1:0] bandgap_level,
    input wire logic [8*LEVEL_W-1:0] converter_channel_pins,
    input wire logic pos_pin_digital,
    input wire logic neg_pin_digital,
    input wire logic irq_vector_ack,
    output logic cmp_raw,
    output logic cmp_power_off,
    output logic capture_trigger,
    output logic pos_port_bit,
    output logic neg_port_bit,
    output logic pos_digin_buf_off,
    output logic neg_digin_buf_off,
    output logic irq
);
    acc_state_t s_q;
    acc_state_t s_d;
    logic [LEVEL_W-1:0] pos_level;
    logic [LEVEL_W-1:0] neg_level;
    logic evt;
    logic wr_en;
    logic flag_clr;
    logic [LEVEL_W-1:0] chan_sel_level;

    // Picks one channel level from the flat bus
    function automatic logic [LEVEL_W-1:0] chan_level(
        input logic [8*LEVEL_W-1:0] levels, input logic [2:0] ch);
        chan_level = levels[32'(ch)*LEVEL_W +: LEVEL_W];
    endfunction

    // Word match on a byte address
    function automatic logic addr_hit(input logic [7:0] a,
        input logic [7:0] ofs);
        addr_hit = (a[7:2] == ofs[7:2]);
    endfunction

    // Input selection for the comparator
    always_comb begin
        pos_level = s_q.bandgap_select ? bandgap_level :
            cmp_pos_pin;
        if (s_q.neg_mux_enable && !s_q.converter_enable) begin
            neg_level = chan_level(converter_channel_pins,
                s_q.channel_select);
        end else begin
            neg_level = cmp_neg_pin;
        end
    end

    // Edge event against the selected mode
    always_comb begin
        case (s_q.irq_mode)
            ACC_MODE_TOGGLE: evt = s_q.cmp_output_status != s_q.out_prev;
            ACC_MODE_FALL: evt = s_q.out_prev && !s_q.cmp_output_status;
            ACC_MODE_RISE: evt = !s_q.out_prev && s_q.cmp_output_status;
            default: evt = 1'b0;
        endcase
    end

    assign wr_en = s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.wstb;
    assign flag_clr = irq_vector_ack ||
        (wr_en && addr_hit(s_q.awaddr, ACC_OFS_CTRL_STATUS) &&
        s_q.wdata[ACC_B_FLAG]) ||
        (wr_en && addr_hit(s_q.awaddr, ACC_OFS_IRQ_STATUS) &&
        s_q.wdata[ACC_B_EVT]);

    // Next state: bus slave, registers and comparator pipeline
    always_comb begin
        s_d = s_q;
        // Write address and data, taken in either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata[7:0];
            s_d.wstb = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Register write once both halves are held
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = ACC_RESP_OKAY;
            if (addr_hit(s_q.awaddr, ACC_OFS_CTRL_STATUS)) begin
                if (s_q.wstb) begin
                    s_d.cmp_disable = s_q.wdata[ACC_B_DISABLE];
                    s_d.bandgap_select = s_q.wdata[ACC_B_BANDGAP];
                    s_d.cmp_irq_enable = s_q.wdata[ACC_B_IRQ_EN];
                    s_d.capture_route_enable = s_q.wdata[ACC_B_CAPTURE];
                    s_d.irq_mode = s_q.wdata[ACC_B_MODE +: 2];
                end
            end else if (addr_hit(s_q.awaddr, ACC_OFS_CONV_B)) begin
                if (s_q.wstb) begin
                    s_d.neg_mux_enable = s_q.wdata[ACC_B_NEG_MUX];
                end
            end else if (addr_hit(s_q.awaddr, ACC_OFS_DIGIN_DIS)) begin
                if (s_q.wstb) begin
                    s_d.neg_pin_digin_disable = s_q.wdata[ACC_B_NEG_DIGIN];
                    s_d.pos_pin_digin_disable = s_q.wdata[ACC_B_POS_DIGIN];
                end
            end else if (addr_hit(s_q.awaddr, ACC_OFS_MISC)) begin
                if (s_q.wstb) begin
                    s_d.converter_enable = s_q.wdata[ACC_B_CONV_EN];
                    s_d.channel_select = s_q.wdata[ACC_B_CHAN +: 3];
                    s_d.global_irq_enable = s_q.wdata[ACC_B_GIE];
                end
            end else if (addr_hit(s_q.awaddr, ACC_OFS_IRQ_MASK)) begin
                if (s_q.wstb) begin
                    s_d.irq_mask = s_q.wdata[ACC_B_EVT];
                end
            end else if (!addr_hit(s_q.awaddr, ACC_OFS_IRQ_STATUS)) begin
                s_d.bresp = ACC_RESP_SLVERR;
            end
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        // Read channel, one word of data the cycle after the address
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = ACC_RESP_OKAY;
            if (addr_hit(s_axi_araddr, ACC_OFS_CTRL_STATUS)) begin
                s_d.rdata[7:0] = {s_q.cmp_disable, s_q.bandgap_select,
                    s_q.cmp_output_status, s_q.cmp_irq_flag,
                    s_q.cmp_irq_enable, s_q.capture_route_enable,
                    s_q.irq_mode};
            end else if (addr_hit(s_axi_araddr, ACC_OFS_CONV_B)) begin
                s_d.rdata[ACC_B_NEG_MUX] = s_q.neg_mux_enable;
            end else if (addr_hit(s_axi_araddr, ACC_OFS_DIGIN_DIS)) begin
                s_d.rdata[ACC_B_NEG_DIGIN] = s_q.neg_pin_digin_disable;
                s_d.rdata[ACC_B_POS_DIGIN] = s_q.pos_pin_digin_disable;
            end else if (addr_hit(s_axi_araddr, ACC_OFS_MISC)) begin
                s_d.rdata[ACC_B_CONV_EN] = s_q.converter_enable;
                s_d.rdata[ACC_B_CHAN +: 3] = s_q.channel_select;
                s_d.rdata[ACC_B_GIE] = s_q.global_irq_enable;
            end else if (addr_hit(s_axi_araddr, ACC_OFS_IRQ_STATUS)) begin
                s_d.rdata[ACC_B_EVT] = s_q.cmp_irq_flag;
            end else if (addr_hit(s_axi_araddr, ACC_OFS_IRQ_MASK)) begin
                s_d.rdata[ACC_B_EVT] = s_q.irq_mask;
            end else begin
                s_d.rresp = ACC_RESP_SLVERR;
            end
        end
        s_d.arready = !s_d.rvalid;
        // Comparator, powered off reads low
        s_d.cmp_raw = !s_q.cmp_disable && (pos_level > neg_level);
        s_d.sync1 = s_q.cmp_raw;
        s_d.cmp_output_status = s_q.sync1;
        s_d.out_prev = s_q.cmp_output_status;
        // Sticky flag, a new event beats a clear
        s_d.cmp_irq_flag = (s_q.cmp_irq_flag && !flag_clr) || evt;
        s_d.irq = s_d.cmp_irq_flag && s_d.cmp_irq_enable &&
            s_d.global_irq_enable && s_d.irq_mask;
        s_d.capture_trigger = s_q.capture_route_enable &&
            s_q.cmp_output_status;
        s_d.pos_port_bit = !s_q.pos_pin_digin_disable &&
            pos_pin_digital;
        s_d.neg_port_bit = !s_q.neg_pin_digin_disable && neg_pin_digital;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= ACC_RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign cmp_raw = s_q.cmp_raw;
    assign cmp_power_off = s_q.cmp_disable;
    assign capture_trigger = s_q.capture_trigger;
    assign pos_port_bit = s_q.pos_port_bit;
    assign neg_port_bit = s_q.neg_port_bit;
    assign pos_digin_buf_off = s_q.pos_pin_digin_disable;
    assign neg_digin_buf_off = s_q.neg_pin_digin_disable;
    assign irq = s_q.irq;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_raw_rise;
        $rose(s_q.cmp_raw);
    endsequence
    sequence s_status_follows;
        ##2 s_q.cmp_output_status;
    endsequence
    sequence s_raw_fall;
        $fell(s_q.cmp_raw);
    endsequence
    sequence s_status_low;
        ##2 !s_q.cmp_output_status;
    endsequence

    // Channel level on the mux path, for the path check
    assign chan_sel_level = chan_level(converter_channel_pins,
        s_q.channel_select);

    chk_raw_compare: assert property (
        !s_q.cmp_disable |=> cmp_raw == ($past(pos_level) > $past(neg_level)))
        else $error("raw result does not follow the compare");
    chk_neg_pin_path: assert property (
        (!s_q.neg_mux_enable || s_q.converter_enable) && !s_q.cmp_disable
        |=> cmp_raw == ($past(pos_level) > $past(cmp_neg_pin)))
        else $error("negative pin not used");
    chk_bandgap_path: assert property (
        s_q.bandgap_select && !s_q.cmp_disable
        |=> cmp_raw == ($past(bandgap_level) > $past(neg_level)))
        else $error("bandgap not on positive input");
    chk_disable_power: assert property (
        s_q.cmp_disable |-> cmp_power_off ##1 !cmp_raw)
        else $error("disabled comparator still drives");
    chk_sync_latency: assert property (
        s_raw_rise |-> s_status_follows)
        else $error("status not two cycles behind raw");
    chk_flag_set: assert property (
        evt |=> s_q.cmp_irq_flag)
        else $error("event did not set flag");
    chk_flag_clear: assert property (
        irq_vector_ack && !evt |=> !s_q.cmp_irq_flag)
        else $error("vector ack did not clear flag");
    chk_irq_gate: assert property (
        !s_q.cmp_irq_enable || !s_q.global_irq_enable |-> !irq)
        else $error("interrupt without enables");
    chk_mode_reserved: assert property (
        s_q.irq_mode == ACC_MODE_RSVD && !s_q.cmp_irq_flag
        |=> !s_q.cmp_irq_flag)
        else $error("reserved mode raised flag");
    chk_capture_route: assert property (
        !s_q.capture_route_enable |=> !capture_trigger)
        else $error("capture driven while unrouted");
    chk_digin_zero: assert property (
        s_q.pos_pin_digin_disable |=> !pos_port_bit)
        else $error("disabled pin reads nonzero");
    chk_rise_event: assert property (
        s_q.irq_mode == ACC_MODE_RISE && !s_q.out_prev &&
        s_q.cmp_output_status |=> s_q.cmp_irq_flag)
        else $error("rising edge missed");
    chk_chan_path: assert property (
        s_q.neg_mux_enable && !s_q.converter_enable && !s_q.cmp_disable
        |=> cmp_raw == ($past(pos_level) > $past(chan_sel_level)))
        else $error("channel not on negative input");
    chk_sync_fall: assert property (
        s_raw_fall |-> s_status_low)
        else $error("status not two cycles behind raw fall");
    chk_toggle_event: assert property (
        s_q.irq_mode == ACC_MODE_TOGGLE &&
        s_q.cmp_output_status != s_q.out_prev |=> s_q.cmp_irq_flag)
        else $error("toggle missed");
    chk_fall_event: assert property (
        s_q.irq_mode == ACC_MODE_FALL && s_q.out_prev &&
        !s_q.cmp_output_status |=> s_q.cmp_irq_flag)
        else $error("falling edge missed");
    chk_flag_sticky: assert property (
        s_q.cmp_irq_flag && !flag_clr |=> s_q.cmp_irq_flag)
        else $error("flag dropped without a clear");
    chk_flag_w1c: assert property (
        wr_en && addr_hit(s_q.awaddr, ACC_OFS_IRQ_STATUS) &&
        s_q.wdata[ACC_B_EVT] && !evt |=> !s_q.cmp_irq_flag)
        else $error("software clear did not clear flag");
    chk_capture_follow: assert property (
        s_q.capture_route_enable
        |=> capture_trigger == $past(s_q.cmp_output_status))
        else $error("capture does not follow output");
    chk_port_pass: assert property (
        !s_q.neg_pin_digin_disable |=> neg_port_bit == $past(neg_pin_digital))
        else $error("enabled pin does not pass");
    chk_neg_digin_zero: assert property (
        s_q.neg_pin_digin_disable |=> !neg_port_bit)
        else $error("disabled negative pin reads nonzero");
    // Bus answers stand until the master takes them
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
endmodule // acc_top

`default_nettype wire

// ---- test/test_analog_comparator_control.sv ----
/*
 * Self-checking bench for the analog comparator control block: register
 * reset values, input selection, synchronised status, event modes, flag,
 * interrupt gating, power off, capture routing, digital input disable.
 * Assumes acc_pkg and acc_top compiled first; one 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_analog_comparator_control;
    import acc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [9:0] pos = 10'h000, neg = 10'h000, bgap = 10'h000;
    logic [79:0] chans = 80'h0;
    logic pos_dig = 1'b0, neg_dig = 1'b0, ack = 1'b0;
    logic raw, pwr_off, cap, pos_bit, neg_bit, pos_off, neg_off, irq;
    logic [31:0] rdat;
    logic [1:0] rsp;
    int n_mismatch = 0;
    int check_count = 0;

    // Free-running system clock
    always #4 aclk = ~aclk;

    acc_top u_acc_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cmp_pos_pin(pos), .cmp_neg_pin(neg),
        .bandgap_level(bgap), .converter_channel_pins(chans),
        .pos_pin_digital(pos_dig), .neg_pin_digital(neg_dig),
        .irq_vector_ack(ack), .cmp_raw(raw), .cmp_power_off(pwr_off),
        .capture_trigger(cap), .pos_port_bit(pos_bit),
        .neg_port_bit(neg_bit), .pos_digin_buf_off(pos_off),
        .neg_digin_buf_off(neg_off), .irq(irq)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // Bounded wait ran out: count it and close the run
    task automatic hang(input string nm);
        $display("BAD %s expected answer seen timeout", nm);
        n_mismatch++;
        print_verdict();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw;
        bit w;
        int n;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; !(aw && w); n++) begin
            if (n > 50) hang("write");
            @(posedge aclk);
            if (s_axi_awready && !aw) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        n = 0;
        do begin
            if (n++ > 50) hang("bresp");
            @(posedge aclk);
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            if (n++ > 50) hang("read");
            @(posedge aclk);
        end while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        n = 0;
        do begin
            if (n++ > 50) hang("rdata");
            @(posedge aclk);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rsp);
    endtask

    // Read a register and compare the masked bits
    task automatic ex(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
        rd(a, rdat, rsp);
        chk(nm, e, rdat & m);
    endtask

    // Main sequence
    initial begin
        int i;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        for (i = 0; i < 6; i++) begin
            ex("reset value", 8'h30 + 8'(4 * i), 32'hFFFFFFFF, 32'h0);
        end
        rd(8'h4C, rdat, rsp);
        chk("unmapped rresp", 32'(ACC_RESP_SLVERR), 32'(rsp));
        chk("unmapped rdata", 32'h0, rdat);
        wr(8'h4C, 32'h1, rsp);
        chk("unmapped bresp", 32'(ACC_RESP_SLVERR), 32'(rsp));
        s_axi_wstrb <= 4'h0;
        wreg(ACC_OFS_MISC, 32'h1F);
        s_axi_wstrb <= 4'hF;
        chk("strobe bresp", 32'(ACC_RESP_OKAY), 32'(rsp));
        ex("strobe off", ACC_OFS_MISC, 32'hFF, 32'h0);
        $display("test registers done");
        neg <= 10'h0C8;
        pos <= 10'h064;
        tick(6);
        ex("out below", ACC_OFS_CTRL_STATUS, 32'h20, 32'h0);
        pos <= 10'h12C;
        tick(6);
        ex("out above", ACC_OFS_CTRL_STATUS, 32'h20, 32'h20);
        pos <= 10'h0C8;
        tick(6);
        ex("out equal", ACC_OFS_CTRL_STATUS, 32'h20, 32'h0);
        bgap <= 10'h1F4;
        pos <= 10'h000;
        wreg(ACC_OFS_CTRL_STATUS, 32'h40);
        tick(6);
        ex("bandgap hi", ACC_OFS_CTRL_STATUS, 32'h20, 32'h20);
        bgap <= 10'h064;
        tick(6);
        ex("bandgap lo", ACC_OFS_CTRL_STATUS, 32'h20, 32'h0);
        wreg(ACC_OFS_CTRL_STATUS, 32'h0);
        $display("test positive input done");
        for (i = 0; i < 8; i++) begin
            chans[i*10 +: 10] <= 10'(i * 100);
        end
        neg <= 10'h3FF;
        pos <= 10'h15E;
        wreg(ACC_OFS_CONV_B, 32'h40);
        for (i = 0; i < 8; i++) begin
            wreg(ACC_OFS_MISC, 32'(i << 1));
            tick(6);
            ex("channel", ACC_OFS_CTRL_STATUS, 32'h20,
               (i < 4) ? 32'h20 : 32'h0);
        end
        wreg(ACC_OFS_MISC, 32'h1);
        tick(6);
        ex("converter on", ACC_OFS_CTRL_STATUS, 32'h20, 32'h0);
        wreg(ACC_OFS_CONV_B, 32'h0);
        wreg(ACC_OFS_MISC, 32'h0);
        $display("test negative input done");
        neg <= 10'h1F4;
        pos <= 10'h000;
        tick(6);
        for (i = 0; i < 4; i++) begin
            wreg(ACC_OFS_CTRL_STATUS, 32'h10 | 32'(i));
            pos <= 10'h3FF;
            tick(6);
            ex("rise flag", ACC_OFS_CTRL_STATUS, 32'h10,
               (i == 0 || i == 3) ? 32'h10 : 32'h0);
            wreg(ACC_OFS_IRQ_STATUS, 32'h1);
            ex("flag w1c", ACC_OFS_IRQ_STATUS, 32'h1, 32'h0);
            pos <= 10'h000;
            tick(6);
            ex("fall flag", ACC_OFS_CTRL_STATUS, 32'h10,
               (i == 0 || i == 2) ? 32'h10 : 32'h0);
        end
        $display("test event modes done");
        wreg(ACC_OFS_CTRL_STATUS, 32'h1B);
        wreg(ACC_OFS_IRQ_MASK, 32'h1);
        pos <= 10'h3FF;
        tick(6);
        chk("irq global off", 32'h0, 32'(irq));
        wreg(ACC_OFS_MISC, 32'h10);
        tick(3);
        chk("irq on", 32'h1, 32'(irq));
        wreg(ACC_OFS_IRQ_MASK, 32'h0);
        tick(3);
        chk("irq masked", 32'h0, 32'(irq));
        wreg(ACC_OFS_IRQ_MASK, 32'h1);
        wreg(ACC_OFS_CTRL_STATUS, 32'h03);
        tick(3);
        chk("irq enable off", 32'h0, 32'(irq));
        wreg(ACC_OFS_CTRL_STATUS, 32'h0B);
        tick(3);
        chk("irq again", 32'h1, 32'(irq));
        ack <= 1'b1;
        @(posedge aclk);
        ack <= 1'b0;
        tick(3);
        chk("irq after vector", 32'h0, 32'(irq));
        ex("flag after vector", ACC_OFS_IRQ_STATUS, 32'h1, 32'h0);
        wreg(ACC_OFS_CTRL_STATUS, 32'h0);
        $display("test interrupt done");
        wreg(ACC_OFS_CTRL_STATUS, 32'h04);
        tick(6);
        chk("capture on", 32'h1, 32'(cap));
        wreg(ACC_OFS_CTRL_STATUS, 32'h0);
        tick(3);
        chk("capture off", 32'h0, 32'(cap));
        wreg(ACC_OFS_CTRL_STATUS, 32'h80);
        tick(6);
        chk("power off", 32'h1, 32'(pwr_off));
        chk("raw when off", 32'h0, 32'(raw));
        ex("out when off", ACC_OFS_CTRL_STATUS, 32'hA0, 32'h80);
        wreg(ACC_OFS_CTRL_STATUS, 32'h0);
        $display("test power and capture done");
        pos_dig <= 1'b1;
        neg_dig <= 1'b1;
        tick(3);
        chk("port bits", 32'h3, {30'h0, neg_bit, pos_bit});
        wreg(ACC_OFS_DIGIN_DIS, 32'h1);
        tick(3);
        chk("pos disabled", 32'h6,
            {29'h0, pos_off, neg_bit, pos_bit});
        wreg(ACC_OFS_DIGIN_DIS, 32'h2);
        tick(3);
        chk("neg disabled", 32'h5,
            {29'h0, neg_off, neg_bit, pos_bit});
        $display("test digital input done");
        print_verdict();
    end
endmodule // test_analog_comparator_control
`default_nettype wire
